// [design/sysref_clock_control_regs.sv]
/*
 * Register bank behind the serial configuration port: stream addressing,
 * sysref alignment controls, clock input modes, edge position readback.
 * Assumes the host holds spi_csb_n high between frames and keeps it low
 * at least 40 ns before the first and after the last spi_sclk edge.
 */
`timescale 1ns/100ps
`default_nettype none

// Function
// - address-hold clear: stream address steps up or down per direction input.
// - address-hold set: every streamed byte uses the same address.
// - bit 6 enables sysref processing; cleared means no events; resets off.
// - bit 5 enables the sysref receiver; resets off.
// - bit 4 selects finer windowing delay steps for status and delays.
// - bits 3:0 choose the applied sysref capture delay.
// - timestamp and marker enables together put sysref on sample lsb.
// - timestamp insertion only with downconverter bypassed, decimation one.
// - bits 2 and 1 select dc-coupled pecl for device clock and sysref.
// - bit 0 inverts the sysref used for alignment.
// - a 24-bit edge position status is readable by the host.
module sysref_clock_control_regs (
  input  wire logic                        ref_clk,
  input  wire logic                        srst,
  input  wire logic                        spi_sclk,
  input  wire logic                        spi_csb_n,
  input  wire logic                        spi_sdi,
  output logic                             spi_sdo,
  output logic                             spi_sdo_oe,
  input  wire logic                        stream_ascend,
  input  wire logic [23:0]                 sync_edge_position,
  input  wire logic                        sysref_in,
  input  wire logic                        sample_marker_enable,
  input  wire logic                        ddc_bypass,
  input  wire logic                        sample_lsb_in,
  output logic                             sample_lsb_out,
  output logic                             sync_event,
  output sysref_regs_pkg::sync_ctrl_t      sync_ctrl
);

  typedef struct packed {
    sysref_regs_pkg::phase_t phase;
    logic [3:0]              bit_cnt;
    logic [14:0]             instr;
    logic                    rd;
    logic [14:0]             addr;
    logic [7:0]              sh_in;
    logic [7:0]              sh_out;
    logic                    wr_tog;
  } link_t;

  typedef struct packed {
    logic [14:0] addr;
    logic [7:0]  data;
  } mail_t;

  typedef struct packed {
    logic [7:0]  stream_cfg;
    logic [7:0]  sync_clk_ctl;
    logic [7:0]  clk_in_ctl;
    logic [23:0] pos_snap;
    logic        tog_s3;
    logic        lsb_out;
    logic        event_out;
  } core_t;

  link_t link_r, link_nxt;
  mail_t mail_r, mail_nxt;
  core_t core_r, core_nxt;
  logic [1:0] stream_mode_sync;
  logic       cs_idle_sync;
  logic       tog_sync;
  logic       srf_sync;

  // frozen image: config changes only by this port, status held in frames
  function automatic logic [7:0] rd_byte(input logic [14:0] a,
                                         input core_t c);
    logic [7:0] d;
    d = 8'h00;
    unique case (a)
      sysref_regs_pkg::SPI_STREAM_CONFIG_ADDR:   d = c.stream_cfg;
      sysref_regs_pkg::SYNC_CLOCK_CONTROL_ADDR:  d = c.sync_clk_ctl;
      sysref_regs_pkg::CLOCK_INPUT_CONTROL_ADDR: d = c.clk_in_ctl;
      sysref_regs_pkg::SYNC_EDGE_POS_ADDR0:      d = c.pos_snap[7:0];
      sysref_regs_pkg::SYNC_EDGE_POS_ADDR1:      d = c.pos_snap[15:8];
      sysref_regs_pkg::SYNC_EDGE_POS_ADDR2:      d = c.pos_snap[23:16];
      default:                                   d = 8'h00;
    endcase
    return d;
  endfunction : rd_byte

  // link side, on the host's clock
  always_comb begin
    logic [15:0] full;
    logic [7:0]  byte_in;
    logic [14:0] next_addr;
    full      = {link_r.instr, spi_sdi};
    byte_in   = {link_r.sh_in[6:0], spi_sdi};
    next_addr = link_r.addr;
    link_nxt  = link_r;
    mail_nxt  = mail_r;
    link_nxt.bit_cnt = link_r.bit_cnt + 4'h1;
    unique case (link_r.phase)
      sysref_regs_pkg::PH_INSTR: begin
        link_nxt.instr = full[14:0];
        if (link_r.bit_cnt == sysref_regs_pkg::INSTR_LAST) begin
          link_nxt.phase   = sysref_regs_pkg::PH_DATA;
          link_nxt.bit_cnt = 4'h0;
          link_nxt.rd      = full[15];
          link_nxt.addr    = full[14:0];
          link_nxt.sh_out  = rd_byte(full[14:0], core_r);
        end
      end
      sysref_regs_pkg::PH_DATA: begin
        link_nxt.sh_in  = byte_in;
        link_nxt.sh_out = {link_r.sh_out[6:0], 1'b0};
        if (link_r.bit_cnt == sysref_regs_pkg::BYTE_LAST) begin
          link_nxt.bit_cnt = 4'h0;
          if (!link_r.rd) begin
            mail_nxt.addr   = link_r.addr;
            mail_nxt.data   = byte_in;
            link_nxt.wr_tog = ~link_r.wr_tog;
          end
          if (stream_mode_sync[1]) begin
            next_addr = link_r.addr;
          end else if (stream_mode_sync[0]) begin
            next_addr = link_r.addr + 15'h0001;
          end else begin
            next_addr = link_r.addr - 15'h0001;
          end
          link_nxt.addr   = next_addr;
          link_nxt.sh_out = rd_byte(next_addr, core_r);
        end
      end
    endcase
  end

  // frame state ends with the frame's own select, no edge needed after it
  always_ff @(posedge spi_sclk or posedge spi_csb_n) begin
    if (spi_csb_n) begin
      link_r <= '0;
    end else begin
      link_r <= link_nxt;
    end
  end

  // mailbox holds the last byte a full byte time for the core to take
  always_ff @(posedge spi_sclk) begin
    mail_r <= mail_nxt;
  end

  // sclk runs only in frames: the first two edges still see the old mode,
  // harmless since the first byte ends at edge 24
  sync_2ff #(
    .W     (2),
    .RST_V (2'b00)
  ) i_mode_sync (
    .clk  (spi_sclk),
    .srst (1'b0),
    .d    ({core_r.stream_cfg[sysref_regs_pkg::ADDR_HOLD_BIT],
            stream_ascend}),
    .q    (stream_mode_sync)
  );

  sync_2ff #(
    .W     (1),
    .RST_V (1'b1)
  ) i_cs_sync (
    .clk  (ref_clk),
    .srst (srst),
    .d    (spi_csb_n),
    .q    (cs_idle_sync)
  );

  sync_2ff #(
    .W     (1),
    .RST_V (1'b0)
  ) i_tog_sync (
    .clk  (ref_clk),
    .srst (srst),
    .d    (link_r.wr_tog),
    .q    (tog_sync)
  );

  sync_2ff #(
    .W     (1),
    .RST_V (1'b0)
  ) i_srf_sync (
    .clk  (ref_clk),
    .srst (srst),
    .d    (sysref_in),
    .q    (srf_sync)
  );

  assign spi_sdo    = link_r.sh_out[7];
  assign spi_sdo_oe = !spi_csb_n && link_r.rd &&
                      (link_r.phase == sysref_regs_pkg::PH_DATA);

  // core side, on ref_clk
  always_comb begin
    logic wr_evt;
    logic srf;
    wr_evt          = tog_sync ^ core_r.tog_s3;
    srf             = srf_sync ^
                      core_r.clk_in_ctl[sysref_regs_pkg::INVERT_BIT];
    core_nxt        = core_r;
    core_nxt.tog_s3 = tog_sync;
    // a rewrite after the frame's end toggle repeats identical data
    if (wr_evt) begin
      unique case (mail_r.addr)
        sysref_regs_pkg::SPI_STREAM_CONFIG_ADDR:
          core_nxt.stream_cfg = mail_r.data;
        sysref_regs_pkg::SYNC_CLOCK_CONTROL_ADDR:
          core_nxt.sync_clk_ctl = mail_r.data;
        sysref_regs_pkg::CLOCK_INPUT_CONTROL_ADDR:
          core_nxt.clk_in_ctl = mail_r.data;
        default: ;
      endcase
    end
    // snapshot only while idle so a read frame sees a steady value
    if (cs_idle_sync) begin
      core_nxt.pos_snap = sync_edge_position;
    end
    core_nxt.event_out = srf &&
      core_r.sync_clk_ctl[sysref_regs_pkg::RECV_EN_BIT] &&
      core_r.sync_clk_ctl[sysref_regs_pkg::PROC_EN_BIT];
    core_nxt.lsb_out = sample_lsb_in;
    if (core_r.clk_in_ctl[sysref_regs_pkg::TIMESTAMP_EN_BIT] &&
        sample_marker_enable && ddc_bypass) begin
      core_nxt.lsb_out = srf;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      core_r              <= '0;
      core_r.stream_cfg   <= sysref_regs_pkg::SPI_STREAM_CONFIG_RST;
      core_r.sync_clk_ctl <= sysref_regs_pkg::SYNC_CLOCK_CONTROL_RST;
      core_r.clk_in_ctl   <= sysref_regs_pkg::CLOCK_INPUT_CONTROL_RST;
      core_r.pos_snap     <= sysref_regs_pkg::SYNC_EDGE_POS_RST;
    end else begin
      core_r <= core_nxt;
    end
  end

  assign sample_lsb_out = core_r.lsb_out;
  assign sync_event     = core_r.event_out;

  always_comb begin
    sync_ctrl.sync_processor_enable =
      core_r.sync_clk_ctl[sysref_regs_pkg::PROC_EN_BIT];
    sync_ctrl.sync_receiver_enable =
      core_r.sync_clk_ctl[sysref_regs_pkg::RECV_EN_BIT];
    sync_ctrl.sync_window_fine_scale =
      core_r.sync_clk_ctl[sysref_regs_pkg::FINE_SCALE_BIT];
    sync_ctrl.sync_delay_select =
      core_r.sync_clk_ctl[sysref_regs_pkg::DELAY_SEL_LSB +:
                          sysref_regs_pkg::DELAY_SEL_W];
    sync_ctrl.sync_timestamp_enable =
      core_r.clk_in_ctl[sysref_regs_pkg::TIMESTAMP_EN_BIT];
    sync_ctrl.device_clock_pecl_mode =
      core_r.clk_in_ctl[sysref_regs_pkg::DEVCLK_PECL_BIT];
    sync_ctrl.sync_input_pecl_mode =
      core_r.clk_in_ctl[sysref_regs_pkg::SYNC_PECL_BIT];
    sync_ctrl.sync_polarity_invert =
      core_r.clk_in_ctl[sysref_regs_pkg::INVERT_BIT];
  end

endmodule : sysref_clock_control_regs

// two-flop synchroniser; only the second flop leaves the module
module sync_2ff #(
  parameter int           W     = 1,
  parameter logic [W-1:0] RST_V = '0
) (
  input  wire logic         clk,
  input  wire logic         srst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_t;

  sync_t sync_r, sync_nxt;

  always_comb begin
    sync_nxt    = sync_r;
    sync_nxt.s1 = d;
    sync_nxt.s2 = sync_r.s1;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      sync_r.s1 <= RST_V;
      sync_r.s2 <= RST_V;
    end else begin
      sync_r <= sync_nxt;
    end
  end

  assign q = sync_r.s2;

endmodule : sync_2ff

`default_nettype wire

// [design/sysref_regs_pkg.sv]
/*
 * Constants and carrier types for the sysref clock control register bank.
 * Assumes a byte-wide serial configuration port with 15-bit addresses.
 */
package sysref_regs_pkg;

  localparam int          ADDR_W            = 15;
  localparam int          INSTR_BITS        = 16;
  localparam logic [3:0]  INSTR_LAST        = 4'hf;
  localparam logic [3:0]  BYTE_LAST         = 4'h7;

  localparam logic [14:0] SPI_STREAM_CONFIG_ADDR   = 15'h0010;
  localparam logic [14:0] SYNC_CLOCK_CONTROL_ADDR  = 15'h0029;
  localparam logic [14:0] CLOCK_INPUT_CONTROL_ADDR = 15'h002a;
  localparam logic [14:0] SYNC_EDGE_POS_ADDR0      = 15'h002c;
  localparam logic [14:0] SYNC_EDGE_POS_ADDR1      = 15'h002d;
  localparam logic [14:0] SYNC_EDGE_POS_ADDR2      = 15'h002e;

  localparam logic [7:0]  SPI_STREAM_CONFIG_RST    = 8'h00;
  localparam logic [7:0]  SYNC_CLOCK_CONTROL_RST   = 8'h00;
  localparam logic [7:0]  CLOCK_INPUT_CONTROL_RST  = 8'h00;
  localparam logic [23:0] SYNC_EDGE_POS_RST        = 24'h000000;

  // spi_stream_config
  localparam int ADDR_HOLD_BIT          = 0;
  // sync_clock_control
  localparam int PROC_EN_BIT            = 6;
  localparam int RECV_EN_BIT            = 5;
  localparam int FINE_SCALE_BIT         = 4;
  localparam int DELAY_SEL_LSB          = 0;
  localparam int DELAY_SEL_W            = 4;
  // clock_input_control
  localparam int TIMESTAMP_EN_BIT       = 3;
  localparam int DEVCLK_PECL_BIT        = 2;
  localparam int SYNC_PECL_BIT          = 1;
  localparam int INVERT_BIT             = 0;

  typedef enum logic {
    PH_INSTR = 1'b0,
    PH_DATA  = 1'b1
  } phase_t;

  typedef struct packed {
    logic       sync_processor_enable;
    logic       sync_receiver_enable;
    logic       sync_window_fine_scale;
    logic [3:0] sync_delay_select;
    logic       sync_timestamp_enable;
    logic       device_clock_pecl_mode;
    logic       sync_input_pecl_mode;
    logic       sync_polarity_invert;
  } sync_ctrl_t;

endpackage : sysref_regs_pkg

// [tb/spi_host_model.sv]
/* serial configuration host: one instruction then bytes, msb first.
   assumes the device samples sdi and shifts sdo on rising sclk. */
`timescale 1ns/100ps
`default_nettype none
module spi_host_model (
  output logic      spi_sclk,
  output logic      spi_csb_n,
  output logic      spi_sdi,
  input  wire logic spi_sdo,
  input  wire logic spi_sdo_oe
);
  int oe_seen = 0;
  // a rising select at start clears the link state
  initial begin
    {spi_sclk, spi_csb_n, spi_sdi} = 3'b000;
    #1 spi_csb_n = 1'b1;
  end
  // sclk stands low outside frames; data in and out left aligned
  task automatic frame(input logic rd, input logic [14:0] a, input int n,
                       input logic [31:0] wd, output logic [31:0] q);
    logic [47:0] sh;
    sh = {rd, a, wd};
    q = 32'h0;
    oe_seen = 0;
    // odd start offset keeps sclk edges off the ref_clk edges
    #3.7 spi_csb_n = 1'b0;
    #40;
    for (int i = 0; i < 16 + 8 * n; i++) begin
      spi_sdi = sh[47-i];
      #16;
      if (i > 15) q[47-i] = spi_sdo;
      if (spi_sdo_oe) oe_seen++;
      spi_sclk = 1'b1;
      #16 spi_sclk = 1'b0;
    end
    #40 spi_csb_n = 1'b1;
    // released line shows the inverse, never stale data
    spi_sdi = ~spi_sdi;
    #40;
  endtask : frame
endmodule : spi_host_model
`default_nettype wire

// [tb/sysref_clock_control_regs_bench.sv]
/* self-checking bench for the sync control register bank.
   assumes the serial host model and the bound port checker. */
`timescale 1ns/100ps
`default_nettype none
module sysref_clock_control_regs_bench;
  logic        ref_clk = 1'b0;
  logic        srst = 1'b1;
  logic        ascend = 1'b1;
  logic [23:0] edge_pos = 24'ha5c3e1;
  logic        sysref_in = 1'b0;
  logic        marker_en = 1'b0;
  logic        bypass = 1'b0;
  logic        lsb_in = 1'b0;
  logic        sclk, csb_n, sdi, sdo, sdo_oe, lsb_out, sync_event;
  logic [31:0] q;
  int          n_errors = 0;
  int          checks_done = 0;
  int          cyc = 0;
  sysref_regs_pkg::sync_ctrl_t ctrl;
  sysref_clock_control_regs i_dut (
    .ref_clk(ref_clk), .srst(srst), .spi_sclk(sclk), .spi_csb_n(csb_n),
    .spi_sdi(sdi), .spi_sdo(sdo), .spi_sdo_oe(sdo_oe),
    .stream_ascend(ascend), .sync_edge_position(edge_pos),
    .sysref_in(sysref_in), .sample_marker_enable(marker_en),
    .ddc_bypass(bypass), .sample_lsb_in(lsb_in), .sample_lsb_out(lsb_out),
    .sync_event(sync_event), .sync_ctrl(ctrl));
  spi_host_model i_host (
    .spi_sclk(sclk), .spi_csb_n(csb_n), .spi_sdi(sdi), .spi_sdo(sdo),
    .spi_sdo_oe(sdo_oe));
  always #4 ref_clk = ~ref_clk;
  task automatic final_report();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : final_report
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      final_report();
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : tick
  task automatic chk(input string what, input logic [31:0] exp, got);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [14:0] a, input int n, input logic [31:0] d);
    i_host.frame(1'b0, a, n, d, q);
    tick(1);
    chk("write oe", 32'h0, 32'(i_host.oe_seen));
  endtask : wr
  task automatic rdc(input string what, input logic [14:0] a, input int n,
                     input logic [31:0] exp);
    i_host.frame(1'b1, a, n, 32'h0, q);
    tick(1);
    chk(what, exp, q);
    chk("read oe", 32'(8 * n), 32'(i_host.oe_seen));
  endtask : rdc
  task automatic t_reset();
    chk("ctrl rst", 32'h0, 32'(ctrl));
    rdc("rst 29", 15'h029, 3, 32'h0);
    rdc("rst 10", 15'h010, 1, 32'h0);
  endtask : t_reset
  task automatic t_stream();
    wr(15'h029, 2, 32'h3af1_0000);
    rdc("no hold", 15'h010, 1, 32'h0);
    ascend = 1'b0;
    rdc("descend", 15'h02a, 2, 32'hf13a_0000);
    chk("fields", 32'h3a1, 32'(ctrl));
    ascend = 1'b1;
  endtask : t_stream
  task automatic t_event();
    // receiver went on in the earlier frame, processor only now
    wr(15'h029, 1, 32'h7a00_0000);
    sysref_in = 1'b1;
    tick(5);
    chk("evt inv", 32'h0, 32'(sync_event));
    sysref_in = 1'b0;
    tick(2);
    chk("evt early", 32'h0, 32'(sync_event));
    tick(1);
    chk("evt", 32'h1, 32'(sync_event));
  endtask : t_event
  task automatic t_stamp();
    wr(15'h02a, 1, 32'h0e00_0000);
    chk("modes", 32'h7ae, 32'(ctrl));
    marker_en = 1'b1;
    bypass = 1'b1;
    sysref_in = 1'b1;
    tick(3);
    chk("stamp", 32'h1, 32'(lsb_out));
    marker_en = 1'b0;
    lsb_in = 1'b1;
    sysref_in = 1'b0;
    tick(1);
    chk("pass", 32'h1, 32'(lsb_out));
  endtask : t_stamp
  task automatic t_position();
    rdc("pos", 15'h02c, 3, 32'he1c3_a500);
    wr(15'h010, 1, 32'h0100_0000);
    rdc("pos hold", 15'h02c, 3, 32'he1e1_e100);
  endtask : t_position
  task automatic t_rerun();
    srst = 1'b1;
    tick(2);
    srst = 1'b0;
    tick(3);
    chk("rerun ctrl", 32'h0, 32'(ctrl));
    chk("rerun pass", 32'h1, 32'(lsb_out));
    rdc("rerun 10", 15'h010, 1, 32'h0);
    // delay select stays zero so auto calibration stays usable
    wr(15'h029, 1, 32'h2000_0000);
    chk("recv only", 32'h200, 32'(ctrl));
  endtask : t_rerun
  initial begin
    repeat (6) @(posedge ref_clk);
    #1 srst = 1'b0;
    tick(3);
    t_reset();
    t_stream();
    t_event();
    t_stamp();
    t_position();
    t_rerun();
    final_report();
  end
endmodule : sysref_clock_control_regs_bench
bind sysref_clock_control_regs sysref_clock_control_regs_monitor i_mon (
  .ref_clk(ref_clk), .srst(srst), .spi_sclk(spi_sclk),
  .spi_csb_n(spi_csb_n), .spi_sdo(spi_sdo), .spi_sdo_oe(spi_sdo_oe),
  .sysref_in(sysref_in), .sample_marker_enable(sample_marker_enable),
  .ddc_bypass(ddc_bypass), .sample_lsb_in(sample_lsb_in),
  .sample_lsb_out(sample_lsb_out), .sync_event(sync_event),
  .sync_ctrl(sync_ctrl));
`default_nettype wire

// [tb/sysref_clock_control_regs_monitor.sv]
/* port checker for the sync control register bank.
   assumes a bind from the bench; everything samples on ref_clk. */
`timescale 1ns/100ps
`default_nettype none
module sysref_clock_control_regs_monitor (
  input wire logic                        ref_clk,
  input wire logic                        srst,
  input wire logic                        spi_sclk,
  input wire logic                        spi_csb_n,
  input wire logic                        spi_sdo,
  input wire logic                        spi_sdo_oe,
  input wire logic                        sysref_in,
  input wire logic                        sample_marker_enable,
  input wire logic                        ddc_bypass,
  input wire logic                        sample_lsb_in,
  input wire logic                        sample_lsb_out,
  input wire logic                        sync_event,
  input wire sysref_regs_pkg::sync_ctrl_t sync_ctrl
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  logic en;
  logic ts_on;
  assign en = sync_ctrl.sync_processor_enable
            & sync_ctrl.sync_receiver_enable;
  assign ts_on = sync_ctrl.sync_timestamp_enable & sample_marker_enable
               & ddc_bypass;
  // oe only with select already low 8 ref_clk cycles before, never right after select falls
  a_oe_needs_select: assert property (
    spi_sdo_oe |-> !$past(spi_csb_n, 8)) else $error("sdo driven early");
  a_event_needs_en: assert property (
    sync_event |-> $past(en)) else $error("event while disabled");
  a_event_recv_off: assert property (
    !sync_ctrl.sync_receiver_enable [*2] |-> !sync_event)
    else $error("event with receiver off");
  a_event_follows: assert property (
    (en && $stable(sync_ctrl)) [*4] |-> sync_event ==
    ($past(sysref_in, 3) ^ sync_ctrl.sync_polarity_invert))
    else $error("event does not track sysref");
  a_lsb_stamp: assert property (
    (ts_on && $stable(sync_ctrl)) [*4] |-> sample_lsb_out ==
    ($past(sysref_in, 3) ^ sync_ctrl.sync_polarity_invert))
    else $error("sample lsb lacks sysref");
  a_lsb_pass: assert property (
    !sync_ctrl.sync_timestamp_enable [*2] |-> sample_lsb_out ==
    $past(sample_lsb_in)) else $error("sample lsb not passed");
  a_ctrl_reset: assert property (
    $fell(srst) |-> sync_ctrl == '0) else $error("controls not cleared");
  a_sdo_holds: assert property (
    spi_sdo_oe && $past(spi_sdo_oe) && !$rose(spi_sclk) |->
    $stable(spi_sdo)) else $error("sdo moved between edges");
  c_event: cover property (sync_event);
  c_read: cover property (spi_sdo_oe);
  c_stamp: cover property (ts_on && sample_lsb_out);
endmodule : sysref_clock_control_regs_monitor
`default_nettype wire
